// ===== rtv_pkg.sv
// constants and types for the remote temperature value and offset registers
// Functional notes
// [R1] Signed high byte: sign bit 7, 64..1 degrees below; read-only at 0x11/0x12.
// [R2] Signed low byte lives at 0x21 for channel 1, 0x22 for channel 2, read-only.
// [R3] Unsigned high byte: bit 7 weighs 128, then 64..1; read at 0x19/0x1a.
// [R4] Unsigned low byte is readable at 0x29 for channel 1, 0x2a for channel 2.
// [R5] Low byte bits 7,6,5 weigh one half, one quarter, one eighth degree.
// [R6] Low byte bit 4 reads zero with filter off, else the 1/16 degree bit.
// [R7] Low byte bit 3 reads zero with filter off, else the 1/32 degree bit.
// [R8] Low byte bits 2 to 0 always read zero.
// [R9] Per-channel read/write offset at 0x31/0x32, reset 0x00, two's complement.
// [R10] Offset bits 6..0 weigh 32 down to one half; range +63.5 to -64.
// [R11] Offset is added to the raw result; the sum is what gets reported.
// [R12] High byte read freezes its low byte until that low byte is read.
// [R13] Two-bit filter setting: 00 off, 01 basic, 11 enhanced, 10 reserved.
// [R14] Value registers change only at the end of that channel's conversion.
`default_nettype none

package rtv_pkg;

  localparam int RTV_CHANNELS = 2;
  localparam int RTV_RAW_W    = 14;  // signed, lsb = 1/32 degree
  localparam int RTV_CODE_W   = 13;  // 8 whole bits, 5 fraction bits
  localparam int RTV_SUM_W    = 15;
  localparam int RTV_OFS_SHIFT = 4;  // offset lsb 1/2 -> 1/32

  localparam logic [7:0] CMD_SIGNED_HIGH   [RTV_CHANNELS] = '{8'h11, 8'h12};
  localparam logic [7:0] CMD_UNSIGNED_HIGH [RTV_CHANNELS] = '{8'h19, 8'h1a};
  localparam logic [7:0] CMD_SIGNED_LOW    [RTV_CHANNELS] = '{8'h21, 8'h22};
  localparam logic [7:0] CMD_UNSIGNED_LOW  [RTV_CHANNELS] = '{8'h29, 8'h2a};
  localparam logic [7:0] CMD_CORRECTION    [RTV_CHANNELS] = '{8'h31, 8'h32};

  localparam logic [7:0] CORRECTION_RESET = 8'h00;
  localparam logic [7:0] LOW_MASK_FILTER   = 8'hf8;
  localparam logic [7:0] LOW_MASK_NOFILTER = 8'he0;
  localparam logic [7:0] RDATA_UNMAPPED    = 8'h00;

  // clamp limits in 1/32 degree steps
  localparam logic signed [RTV_SUM_W-1:0] SIGNED_MAX   = 15'sh0fff;
  localparam logic signed [RTV_SUM_W-1:0] SIGNED_MIN   = 15'sh7000;
  localparam logic signed [RTV_SUM_W-1:0] UNSIGNED_MAX = 15'sh1fff;

  typedef enum logic [1:0] {
    FILT_OFF      = 2'h0,
    FILT_BASIC    = 2'h1,
    FILT_RESERVED = 2'h2,
    FILT_ENHANCED = 2'h3
  } rtv_filter_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } rtv_host_req_t;

  typedef struct packed {
    logic                        done;
    logic signed [RTV_RAW_W-1:0] raw;
  } rtv_conv_t;

endpackage : rtv_pkg

`default_nettype wire

// ===== rtv_regs.sv
// remote temperature value registers, offset correction and low byte lock
`timescale 1ns/1ps
`default_nettype none

module rtv_regs (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire rtv_pkg::rtv_host_req_t req,
  input  wire rtv_pkg::rtv_conv_t    conv     [rtv_pkg::RTV_CHANNELS],
  input  wire rtv_pkg::rtv_filter_t  filt_sel [rtv_pkg::RTV_CHANNELS],
  output var  logic [7:0]            rdata,
  output var  logic                  rd_valid
);
  import rtv_pkg::*;

  localparam int NC = RTV_CHANNELS;

  logic        [RTV_CODE_W-1:0] sgn_code [NC];
  logic        [RTV_CODE_W-1:0] uns_code [NC];
  logic        [7:0]            offset   [NC];
  logic        [7:0]            frz_s    [NC];
  logic        [7:0]            frz_u    [NC];
  logic                         lk_s     [NC];
  logic                         lk_u     [NC];

  logic signed [RTV_SUM_W-1:0]  sum      [NC];
  logic        [RTV_CODE_W-1:0] next_sgn [NC];
  logic        [RTV_CODE_W-1:0] next_uns [NC];
  logic        [7:0]            live_s   [NC];
  logic        [7:0]            live_u   [NC];
  logic        [7:0]            ch_rd    [NC];
  logic                         hit_sh   [NC];
  logic                         hit_uh   [NC];
  logic                         hit_sl   [NC];
  logic                         hit_ul   [NC];
  logic                         hit_ofs  [NC];
  logic                         filt_on  [NC];
  logic        [7:0]            next_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // per-channel decode, correction and formatting

  for (genvar c = 0; c < NC; c++) begin : g_ch
    assign hit_sh[c]  = req.cmd == CMD_SIGNED_HIGH[c];   // [R1]
    assign hit_uh[c]  = req.cmd == CMD_UNSIGNED_HIGH[c]; // [R3]
    assign hit_sl[c]  = req.cmd == CMD_SIGNED_LOW[c];    // [R2]
    assign hit_ul[c]  = req.cmd == CMD_UNSIGNED_LOW[c];  // [R4]
    assign hit_ofs[c] = req.cmd == CMD_CORRECTION[c];    // [R9]

    // any nonzero setting, reserved code included, counts as filtering
    assign filt_on[c] = filt_sel[c] != FILT_OFF; // [R13]

    // offset lsb is 1/2 degree, raw lsb 1/32: shift left by four
    assign sum[c] = $signed({conv[c].raw[RTV_RAW_W-1], conv[c].raw})
                  + $signed({{(RTV_SUM_W-8-RTV_OFS_SHIFT){offset[c][7]}}, offset[c],
                             {RTV_OFS_SHIFT{1'b0}}}); // [R10] [R11]

    // saturate instead of wrapping so a large offset cannot flip the sign
    assign next_sgn[c] = (sum[c] > SIGNED_MAX) ? SIGNED_MAX[RTV_CODE_W-1:0] :
                         (sum[c] < SIGNED_MIN) ? SIGNED_MIN[RTV_CODE_W-1:0] :
                         sum[c][RTV_CODE_W-1:0]; // [R1]
    assign next_uns[c] = (sum[c] > UNSIGNED_MAX) ? UNSIGNED_MAX[RTV_CODE_W-1:0] :
                         sum[c][RTV_SUM_W-1] ? '0 :
                         sum[c][RTV_CODE_W-1:0]; // [R3]

    assign live_s[c] = {sgn_code[c][4:0], 3'h0}
                     & (filt_on[c] ? LOW_MASK_FILTER : LOW_MASK_NOFILTER); // [R5] [R6] [R7] [R8]
    assign live_u[c] = {uns_code[c][4:0], 3'h0}
                     & (filt_on[c] ? LOW_MASK_FILTER : LOW_MASK_NOFILTER); // [R5] [R6] [R7] [R8]

    assign ch_rd[c] = hit_sh[c]  ? sgn_code[c][12:5] :
                      hit_uh[c]  ? uns_code[c][12:5] :
                      hit_sl[c]  ? (lk_s[c] ? frz_s[c] : live_s[c]) :  // [R12]
                      hit_ul[c]  ? (lk_u[c] ? frz_u[c] : live_u[c]) :  // [R12]
                      hit_ofs[c] ? offset[c] : RDATA_UNMAPPED;
  end

  assign next_rdata = ch_rd[0] | ch_rd[1];

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata    <= RDATA_UNMAPPED;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int c = 0; c < NC; c++) begin
      if (reset) begin
        sgn_code[c] <= '0;
        uns_code[c] <= '0;
        offset[c]   <= CORRECTION_RESET; // [R9]
        frz_s[c]    <= '0;
        frz_u[c]    <= '0;
        lk_s[c]     <= 1'b0;
        lk_u[c]     <= 1'b0;
      end else begin
        if (conv[c].done) begin
          sgn_code[c] <= next_sgn[c]; // [R14]
          uns_code[c] <= next_uns[c]; // [R14]
        end
        if (req.wr && hit_ofs[c]) begin
          offset[c] <= req.wdata; // [R9]
        end
        // a fresh high read always re-captures, even while locked
        if (req.rd && hit_sh[c]) begin
          frz_s[c] <= live_s[c]; // [R12]
          lk_s[c]  <= 1'b1;
        end else if (req.rd && hit_sl[c]) begin
          lk_s[c]  <= 1'b0; // [R12]
        end
        if (req.rd && hit_uh[c]) begin
          frz_u[c] <= live_u[c]; // [R12]
          lk_u[c]  <= 1'b1;
        end else if (req.rd && hit_ul[c]) begin
          lk_u[c]  <= 1'b0; // [R12]
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence seq_high_read;
    req.rd && hit_sh[0];
  endsequence

  sequence seq_low_read;
    req.rd && hit_sl[0];
  endsequence

  a_signed_high: assert property ( // [R1]
    req.rd && hit_sh[1] |=> rdata == $past(sgn_code[1][12:5]))
    else $error("signed high byte of channel 2 wrong");

  a_unsigned_high: assert property ( // [R3]
    req.rd && hit_uh[0] |=> rdata == $past(uns_code[0][12:5]) && rd_valid)
    else $error("unsigned high byte of channel 1 wrong");

  a_unsigned_floor: assert property ( // [R3]
    conv[0].done && sum[0] < 0 |=> uns_code[0] == '0)
    else $error("negative sum not floored in unsigned format");

  a_low_fraction: assert property ( // [R5]
    req.rd && hit_sl[0] && !lk_s[0] |=> rdata[7:5] == $past(sgn_code[0][4:2]))
    else $error("low byte fraction bits wrong");

  a_filter_off_zero: assert property ( // [R6] [R7] [R2]
    req.rd && hit_sl[0] && !lk_s[0] && filt_sel[0] == FILT_OFF |=> rdata[4:3] == 2'h0)
    else $error("fine bits not zero with filter off");

  a_filter_on_bits: assert property ( // [R13] [R4]
    req.rd && hit_ul[1] && !lk_u[1] && filt_sel[1] != FILT_OFF
    |=> rdata[4:3] == $past(uns_code[1][1:0]))
    else $error("fine bits missing with filter on");

  a_low_reserved: assert property ( // [R8]
    req.rd && (hit_sl[0] || hit_ul[0] || hit_sl[1] || hit_ul[1]) |=> rdata[2:0] == 3'h0)
    else $error("reserved low bits not zero");

  // write then read on consecutive edges: the new value must already show
  a_offset_write: assert property ( // [R9]
    req.wr && hit_ofs[0] ##1 req.rd && hit_ofs[0] && !req.wr |=> rdata == $past(req.wdata, 2))
    else $error("offset readback wrong");

  a_sum_reported: assert property ( // [R11] [R10]
    conv[1].done && sum[1] <= SIGNED_MAX && sum[1] >= SIGNED_MIN
    |=> $signed(sgn_code[1]) == $past(conv[1].raw) + 16 * $past($signed(offset[1])))
    else $error("corrected value not reported");

  a_lock_freeze: assert property ( // [R12]
    seq_high_read ##1 seq_low_read |=> rdata == $past(live_s[0], 2))
    else $error("low byte not frozen by high read");

  a_hold_between: assert property ( // [R14]
    !conv[0].done |=> $stable(sgn_code[0]) && $stable(uns_code[0]))
    else $error("value changed outside conversion end");

  //////////////////////////////////////////////////////////////////////////////
  // bus answer timing, shared by both channels

  a_answer_pulse: assert property (
    req.rd |=> rd_valid)
    else $error("read not answered one cycle later");

  a_answer_idle: assert property (
    !req.rd |=> !rd_valid)
    else $error("read valid without a read");

  a_rdata_hold: assert property (
    !req.rd |=> $stable(rdata))
    else $error("read data moved without a read");

  a_unmapped_zero: assert property (
    req.rd && !(hit_sh[0] || hit_uh[0] || hit_sl[0] || hit_ul[0] || hit_ofs[0])
           && !(hit_sh[1] || hit_uh[1] || hit_sl[1] || hit_ul[1] || hit_ofs[1])
    |=> rdata == RDATA_UNMAPPED)
    else $error("unmapped command did not read zero");

  //////////////////////////////////////////////////////////////////////////////
  // per-channel checks, both channels covered

  for (genvar c = 0; c < NC; c++) begin : g_chk

    sequence seq_sh_rd;
      req.rd && hit_sh[c];
    endsequence

    sequence seq_uh_rd;
      req.rd && hit_uh[c];
    endsequence

    a_sh_value: assert property ( // [R1]
      seq_sh_rd |=> rdata == $past(sgn_code[c][12:5]))
      else $error("signed high byte wrong");

    a_uh_value: assert property ( // [R3]
      seq_uh_rd |=> rdata == $past(uns_code[c][12:5]))
      else $error("unsigned high byte wrong");

    a_sl_live: assert property ( // [R2]
      req.rd && hit_sl[c] && !lk_s[c]
      |=> rdata == $past({sgn_code[c][4:0], 3'h0}
                         & ((filt_sel[c] == FILT_OFF) ? LOW_MASK_NOFILTER : LOW_MASK_FILTER)))
      else $error("signed low byte wrong");

    a_ul_live: assert property ( // [R4]
      req.rd && hit_ul[c] && !lk_u[c]
      |=> rdata == $past({uns_code[c][4:0], 3'h0}
                         & ((filt_sel[c] == FILT_OFF) ? LOW_MASK_NOFILTER : LOW_MASK_FILTER)))
      else $error("unsigned low byte wrong");

    a_fine_masked: assert property ( // [R6] [R7]
      req.rd && (hit_sl[c] || hit_ul[c]) && filt_sel[c] == FILT_OFF |=> rdata[4:0] == 5'h00)
      else $error("fine bits shown with filter off");

    a_reserved_low: assert property ( // [R8]
      req.rd && (hit_sl[c] || hit_ul[c]) |=> rdata[2:0] == 3'h0)
      else $error("reserved low bits not zero");

    a_sl_frozen: assert property ( // [R12]
      req.rd && hit_sl[c] && lk_s[c] |=> rdata == $past(frz_s[c]))
      else $error("locked signed low byte not returned");

    a_ul_frozen: assert property ( // [R12]
      req.rd && hit_ul[c] && lk_u[c] |=> rdata == $past(frz_u[c]))
      else $error("locked unsigned low byte not returned");

    a_s_lock_set: assert property ( // [R12]
      seq_sh_rd |=> lk_s[c] && frz_s[c] == $past(live_s[c]))
      else $error("signed low byte not captured");

    a_u_lock_set: assert property ( // [R12]
      seq_uh_rd |=> lk_u[c] && frz_u[c] == $past(live_u[c]))
      else $error("unsigned low byte not captured");

    a_s_lock_clear: assert property ( // [R12]
      req.rd && hit_sl[c] |=> !lk_s[c])
      else $error("signed lock not released");

    a_u_lock_clear: assert property ( // [R12]
      req.rd && hit_ul[c] |=> !lk_u[c])
      else $error("unsigned lock not released");

    a_s_frz_hold: assert property ( // [R12]
      !(req.rd && hit_sh[c]) |=> $stable(frz_s[c]))
      else $error("signed capture moved without high read");

    a_u_frz_hold: assert property ( // [R12]
      !(req.rd && hit_uh[c]) |=> $stable(frz_u[c]))
      else $error("unsigned capture moved without high read");

    a_ofs_store: assert property ( // [R9]
      req.wr && hit_ofs[c] |=> offset[c] == $past(req.wdata))
      else $error("offset write lost");

    a_ofs_keep: assert property ( // [R9]
      !(req.wr && hit_ofs[c]) |=> $stable(offset[c]))
      else $error("offset changed without a write");

    a_ofs_read: assert property ( // [R9]
      req.rd && hit_ofs[c] |=> rdata == $past(offset[c]))
      else $error("offset readback wrong");

    a_sum_scale: assert property ( // [R10] [R11]
      conv[c].done |-> sum[c] == $signed(conv[c].raw) + 16 * $signed(offset[c]))
      else $error("offset not scaled into the sum");

    a_sgn_pass: assert property ( // [R11]
      conv[c].done && sum[c] <= SIGNED_MAX && sum[c] >= SIGNED_MIN
      |=> sgn_code[c] == $past(sum[c][RTV_CODE_W-1:0]))
      else $error("signed code not the corrected sum");

    a_uns_pass: assert property ( // [R11]
      conv[c].done && sum[c] <= UNSIGNED_MAX && !sum[c][RTV_SUM_W-1]
      |=> uns_code[c] == $past(sum[c][RTV_CODE_W-1:0]))
      else $error("unsigned code not the corrected sum");

    a_sgn_top: assert property ( // [R1]
      conv[c].done && sum[c] > SIGNED_MAX |=> sgn_code[c] == SIGNED_MAX[RTV_CODE_W-1:0])
      else $error("signed code not clamped high");

    a_sgn_bottom: assert property ( // [R1]
      conv[c].done && sum[c] < SIGNED_MIN |=> sgn_code[c] == SIGNED_MIN[RTV_CODE_W-1:0])
      else $error("signed code not clamped low");

    a_uns_top: assert property ( // [R3]
      conv[c].done && sum[c] > UNSIGNED_MAX |=> uns_code[c] == UNSIGNED_MAX[RTV_CODE_W-1:0])
      else $error("unsigned code not clamped high");

    a_uns_bottom: assert property ( // [R3]
      conv[c].done && sum[c][RTV_SUM_W-1] |=> uns_code[c] == '0)
      else $error("unsigned code not floored");

    a_code_hold: assert property ( // [R14]
      !conv[c].done |=> $stable(sgn_code[c]) && $stable(uns_code[c]))
      else $error("value changed outside conversion end");

    a_filt_enable: assert property ( // [R13]
      req.rd && hit_ul[c] && !lk_u[c] && filt_sel[c] != FILT_OFF
      |=> rdata[4:3] == $past(uns_code[c][1:0]))
      else $error("fine bits missing with filter on");

  end

endmodule : rtv_regs

`default_nettype wire

// ===== rtv_host_model.sv
// host side model issuing register byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module rtv_host_model (
  input  wire logic                   clock,
  output var  rtv_pkg::rtv_host_req_t req,
  input  wire logic [7:0]             rdata,
  input  wire logic                   rd_valid
);
  import rtv_pkg::*;
  initial req = '0;
  // single byte read; data taken 1 ns after the edge that answers it
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, cmd: cmd, wdata: 8'h00};
    @(posedge clock);
    // idle fields scrambled so a stale command never helps
    req <= '{rd: 1'b0, wr: 1'b0, cmd: ~cmd, wdata: 8'hff};
    #1 data = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask : rd
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b1, cmd: cmd, wdata: data};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, cmd: ~cmd, wdata: ~data};
  endtask : wr
  // high then low read on consecutive edges
  task automatic rd_pair(input logic [7:0] hcmd, input logic [7:0] lcmd,
                         output logic [7:0] hdata, output logic [7:0] ldata);
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, cmd: hcmd, wdata: 8'h00};
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, cmd: lcmd, wdata: 8'h00};
    #1 hdata = (rd_valid === 1'b1) ? rdata : 8'hxx;
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, cmd: ~lcmd, wdata: 8'hff};
    #1 ldata = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask : rd_pair
  // write immediately followed by a read of the same command
  task automatic wr_rd(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] data);
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b1, cmd: cmd, wdata: wdat};
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, cmd: cmd, wdata: 8'h00};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, cmd: ~cmd, wdata: ~wdat};
    #1 data = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask : wr_rd
endmodule : rtv_host_model
`default_nettype wire

// ===== test_remote_temp_value_offset_regs.sv
// self-checking bench for the remote value and offset registers
`timescale 1ns/1ps
`default_nettype none
module test_remote_temp_value_offset_regs;
  import rtv_pkg::*;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  rtv_host_req_t req;
  rtv_conv_t     conv [RTV_CHANNELS];
  rtv_filter_t   filt [RTV_CHANNELS];
  logic [7:0]    rdata;
  logic          rd_valid;
  logic [13:0]   raw [2];
  logic [7:0]    ofs [2];
  logic [7:0]    d;
  logic [7:0]    lo;
  int            err_count = 0;
  int            n_checks = 0;
  always #12.5 clock = ~clock;
  rtv_regs u_dut (.clock(clock), .reset(reset), .req(req), .conv(conv), .filt_sel(filt),
                  .rdata(rdata), .rd_valid(rd_valid));
  rtv_host_model u_host (.clock(clock), .req(req), .rdata(rdata), .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // sum in 1/32 degree steps, saturated to the format's range
  function automatic logic [7:0] exp_b(logic [13:0] r, logic [7:0] o, bit uns, bit low, logic [1:0] f);
    int          s;
    logic [12:0] c;
    s = $signed(r) + $signed(o) * 16;
    if (uns) s = (s < 0) ? 0 : (s > 8191) ? 8191 : s;
    else s = (s < -4096) ? -4096 : (s > 4095) ? 4095 : s;
    c = 13'(s);
    return low ? ({c[4:0], 3'h0} & ((f == 2'h0) ? 8'he0 : 8'hf8)) : c[12:5];
  endfunction : exp_b
  task automatic convert(int c, logic [13:0] r);
    @(posedge clock);
    conv[c] <= '{done: 1'b1, raw: r};
    raw[c] = r;
    @(posedge clock);
    conv[c] <= '{done: 1'b0, raw: ~r};
  endtask : convert
  task automatic chk_chan(int c);
    for (int u = 0; u < 2; u++) begin
      u_host.rd(8'h11 + 8'(8 * u + c), d);
      check(d, exp_b(raw[c], ofs[c], u, 0, filt[c]));
      u_host.rd(8'h21 + 8'(8 * u + c), d);
      check(d, exp_b(raw[c], ofs[c], u, 1, filt[c]));
    end
  endtask : chk_chan
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (conv[i]) conv[i] = '0;
    foreach (filt[i]) filt[i] = FILT_OFF;
    foreach (raw[i]) raw[i] = '0;
    foreach (ofs[i]) ofs[i] = '0;
    void'($urandom(32'hbbaf6bd1));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      u_host.rd(8'h31 + 8'(c), d);
      check(d, 8'h00);
      chk_chan(c);
    end
    u_host.rd(8'h40, d);
    check(d, 8'h00);
    u_host.wr(8'h11, 8'h5a);
    chk_chan(0);
    // first two passes drive both saturation corners
    for (int i = 0; i < 40; i++) begin
      for (int c = 0; c < 2; c++) begin
        ofs[c] = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom);
        filt[c] <= rtv_filter_t'(2'(i + c));
        u_host.wr(8'h31 + 8'(c), ofs[c]);
        u_host.rd(8'h31 + 8'(c), d);
        check(d, ofs[c]);
        convert(c, (i == 0) ? 14'h1fff : (i == 1) ? 14'h2000 : 14'($urandom));
        chk_chan(c);
      end
    end
    ofs[0] = 8'h00;
    filt[0] <= FILT_ENHANCED;
    u_host.wr(8'h31, 8'h00);
    convert(0, 14'h0123);
    u_host.rd(8'h11, d);
    lo = exp_b(raw[0], 8'h00, 0, 1, 2'h3);
    convert(0, 14'h01dc);
    u_host.rd(8'h21, d);
    check(d, lo);
    u_host.rd(8'h21, d);
    check(d, exp_b(raw[0], 8'h00, 0, 1, 2'h3));
    u_host.rd(8'h19, d);
    convert(0, 14'h0155);
    u_host.rd(8'h19, d);
    lo = exp_b(raw[0], 8'h00, 1, 1, 2'h3);
    convert(0, 14'h01aa);
    u_host.rd(8'h29, d);
    check(d, lo);
    u_host.rd_pair(8'h11, 8'h21, d, lo);
    check(d, exp_b(raw[0], 8'h00, 0, 0, 2'h3));
    check(lo, exp_b(raw[0], 8'h00, 0, 1, 2'h3));
    u_host.wr_rd(8'h31, 8'h3c, d);
    check(d, 8'h3c);
    test_done();
  end
endmodule : test_remote_temp_value_offset_regs
`default_nettype wire
